/* File: hw/fir_bank.sv */
// flash control register bank with identification words
`timescale 1ns/1ps
module fir_bank #(
  parameter logic [10:0] MAKER_CODE = 11'h155, // arbitrary value
  parameter logic [11:0] CHIP_CODE = 12'hA5C, // arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // boot strap pin and flash status
  input wire logic external_boot_select_n_i,
  input wire logic flash_init_done_i,
  // internal peripheral bus
  input wire fir_pkg::fir_req_s internal_peripheral_bus_req_i,
  output fir_pkg::fir_rsp_s internal_peripheral_bus_rsp_o,
  // expansion peripheral bus
  input wire fir_pkg::fir_req_s expansion_peripheral_bus_req_i,
  output fir_pkg::fir_rsp_s expansion_peripheral_bus_rsp_o,
  // extended sfr space
  input wire fir_pkg::fir_req_s extended_sfr_space_req_i,
  output fir_pkg::fir_rsp_s extended_sfr_space_rsp_o,
  // register contents towards the flash
  output logic [fir_pkg::NCTRL-1:0][fir_pkg::DW-1:0] flash_ctrl_o,
  output logic [fir_pkg::DW-1:0] flash_unprot_o,
  output logic id_valid_o
);
  import fir_pkg::*;

  fir_state_s q;
  fir_state_s d;
  logic [IW-1:0] ib_idx;
  logic ib_ok;
  logic id_hit;
  logic [DW-1:0] id_data;
  logic [DW-1:0] mem_word;

  function automatic logic [IW-1:0] reg_index(input logic [AW-1:0] a);
    logic [IW-1:0] r;
    r = IDX_NONE;
    for (int i = 0; i < NREG; i++) begin
      if (REG_ADDR[i] == a) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // word-only access, no bit instructions
  function automatic logic whole_word(input fir_req_s r);
    return r.word && !r.bitop;
  endfunction

  assign ib_idx = reg_index(internal_peripheral_bus_req_i.addr);
  assign ib_ok = (ib_idx != IDX_NONE) && whole_word(internal_peripheral_bus_req_i);

  // defaults until the flash reports ready
  assign mem_word = (q.phase == FIR_PH_READY) ?
    {FIR_KIND_FAST, MEM_CAPACITY} :
    {FIR_KIND_UNSET, MEM_CAPACITY};

  always_comb begin
    id_hit = 1'b1;
    case (extended_sfr_space_req_i.addr)
      ADDR_PROG_ID: id_data = {PROG_HIGH_V, PROG_SUPPLY};
      ADDR_MEM_ID: id_data = mem_word;
      ADDR_CHIP_ID: id_data = {CHIP_CODE, REVISION};
      ADDR_MAKER_ID: id_data = {MAKER_CODE, MAKER_TAIL};
      default: begin
        id_hit = 1'b0;
        id_data = '0;
      end
    endcase
  end

  always_comb begin
    d = q;
    d.boot_sync = {q.boot_sync[0], external_boot_select_n_i};
    d.ib = '0;
    d.xb = '0;
    d.es = '0;

    // strap is taken once the synchroniser has filled after reset
    case (q.phase)
      FIR_PH_SYNC: begin
        if (q.fill == SYNC_FILL) begin
          // internal boot: flash is already initialised
          d.phase = q.boot_sync[1] ? FIR_PH_READY : FIR_PH_INIT;
        end else begin
          d.fill = q.fill + 2'h1;
        end
      end
      FIR_PH_INIT: begin
        if (flash_init_done_i) begin
          d.phase = FIR_PH_READY;
        end
      end
      FIR_PH_READY: d.phase = FIR_PH_READY;
      default: d.phase = FIR_PH_SYNC;
    endcase

    if (internal_peripheral_bus_req_i.req) begin
      d.ib.ack = 1'b1;
      if (!ib_ok) begin
        d.ib.err = 1'b1;
      end else if (internal_peripheral_bus_req_i.we) begin
        d.regs[ib_idx] = internal_peripheral_bus_req_i.wdata;
      end else begin
        d.ib.rdata = q.regs[ib_idx];
      end
    end

    if (expansion_peripheral_bus_req_i.req) begin
      d.xb.ack = 1'b1;
      if (expansion_peripheral_bus_req_i.addr != ADDR_UNPROT || !whole_word(expansion_peripheral_bus_req_i)) begin
        d.xb.err = 1'b1;
      end else if (expansion_peripheral_bus_req_i.we) begin
        d.unprot = expansion_peripheral_bus_req_i.wdata;
      end else begin
        d.xb.rdata = q.unprot;
      end
    end

    // writes to identification words are acknowledged and dropped
    if (extended_sfr_space_req_i.req) begin
      d.es.ack = 1'b1;
      if (!id_hit) begin
        d.es.err = 1'b1;
      end else if (!extended_sfr_space_req_i.we) begin
        d.es.rdata = id_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign internal_peripheral_bus_rsp_o = q.ib;
  assign expansion_peripheral_bus_rsp_o = q.xb;
  assign extended_sfr_space_rsp_o = q.es;
  assign flash_ctrl_o = q.regs[NCTRL-1:0];
  assign flash_unprot_o = q.unprot;
  assign id_valid_o = (q.phase == FIR_PH_READY);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_internal_peripheral_bus_bitop_refused: assert property (
    internal_peripheral_bus_req_i.req && internal_peripheral_bus_req_i.bitop |=> internal_peripheral_bus_rsp_o.err && $stable(q.regs))
    else $error("bit access to flash register not refused");

  a_expansion_peripheral_bus_unprot_write: assert property (
    expansion_peripheral_bus_req_i.req && expansion_peripheral_bus_req_i.we && whole_word(expansion_peripheral_bus_req_i) &&
    expansion_peripheral_bus_req_i.addr == ADDR_UNPROT
    |=> flash_unprot_o == $past(expansion_peripheral_bus_req_i.wdata) && !expansion_peripheral_bus_rsp_o.err)
    else $error("unprotect register write lost");

  a_internal_peripheral_bus_no_unprot: assert property (
    internal_peripheral_bus_req_i.req && internal_peripheral_bus_req_i.addr == ADDR_UNPROT |=> internal_peripheral_bus_rsp_o.err)
    else $error("unprotect register answered on peripheral bus");

  a_id_write_ignored: assert property (
    extended_sfr_space_req_i.req && extended_sfr_space_req_i.we && id_hit
    |=> extended_sfr_space_rsp_o.ack && !extended_sfr_space_rsp_o.err && extended_sfr_space_rsp_o.rdata == '0)
    else $error("identification write not ignored");

  a_chip_word_layout: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_CHIP_ID
    |=> extended_sfr_space_rsp_o.rdata[15:4] == CHIP_CODE && extended_sfr_space_rsp_o.rdata[3:0] == REVISION)
    else $error("chip word layout wrong");

  a_mem_word_ready: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_MEM_ID &&
    id_valid_o |=> extended_sfr_space_rsp_o.rdata == 16'h3040)
    else $error("memory word wrong after init");

  a_prog_word_value: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_PROG_ID
    |=> extended_sfr_space_rsp_o.rdata == 16'h0040)
    else $error("programming word wrong");

  a_mem_word_early: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_MEM_ID &&
    !id_valid_o |=> extended_sfr_space_rsp_o.rdata == 16'hF040)
    else $error("memory word default wrong");

  a_init_wait_held: assert property (
    q.phase == FIR_PH_INIT && !flash_init_done_i |=> !id_valid_o)
    else $error("identification valid before flash init");

  a_internal_boot_fast: assert property (
    $rose(nrst_i) ##0 (external_boot_select_n_i [*3])
    |=> ##[0:2] id_valid_o)
    else $error("internal boot not valid at once");

  a_reset_values: assert property (
    $rose(nrst_i) |-> q.regs == REG_RST && flash_unprot_o == UNPROT_RST)
    else $error("register reset value wrong");

  a_word_only: assert property (
    internal_peripheral_bus_req_i.req && !internal_peripheral_bus_req_i.word |=> internal_peripheral_bus_rsp_o.ack && internal_peripheral_bus_rsp_o.err)
    else $error("partial word access accepted");

  // every answer stands one cycle, then the port falls back to zero
  a_internal_peripheral_bus_answer_once: assert property (
    internal_peripheral_bus_req_i.req
    |=> internal_peripheral_bus_rsp_o.ack)
    else $error("peripheral bus access not answered");

  a_internal_peripheral_bus_rsp_quiet: assert property (
    !internal_peripheral_bus_req_i.req
    |=> internal_peripheral_bus_rsp_o == '0)
    else $error("peripheral bus answer without access");

  a_expansion_peripheral_bus_answer_once: assert property (
    expansion_peripheral_bus_req_i.req
    |=> expansion_peripheral_bus_rsp_o.ack)
    else $error("expansion bus access not answered");

  a_expansion_peripheral_bus_rsp_quiet: assert property (
    !expansion_peripheral_bus_req_i.req
    |=> expansion_peripheral_bus_rsp_o == '0)
    else $error("expansion bus answer without access");

  a_extended_sfr_space_answer_once: assert property (
    extended_sfr_space_req_i.req
    |=> extended_sfr_space_rsp_o.ack)
    else $error("identification access not answered");

  a_extended_sfr_space_rsp_quiet: assert property (
    !extended_sfr_space_req_i.req
    |=> extended_sfr_space_rsp_o == '0)
    else $error("identification answer without access");

  a_internal_peripheral_bus_write_lands: assert property (
    internal_peripheral_bus_req_i.req && internal_peripheral_bus_req_i.we && ib_ok
    |=> q.regs[$past(ib_idx)] == $past(internal_peripheral_bus_req_i.wdata) && !internal_peripheral_bus_rsp_o.err)
    else $error("flash register write lost");

  a_internal_peripheral_bus_read_data: assert property (
    internal_peripheral_bus_req_i.req && !internal_peripheral_bus_req_i.we && ib_ok
    |=> internal_peripheral_bus_rsp_o.rdata == $past(q.regs[ib_idx]) && !internal_peripheral_bus_rsp_o.err)
    else $error("flash register read data wrong");

  a_internal_peripheral_bus_refused_quiet: assert property (
    internal_peripheral_bus_req_i.req && !ib_ok
    |=> internal_peripheral_bus_rsp_o.rdata == '0 && $stable(q.regs))
    else $error("refused access changed or showed a register");

  a_internal_peripheral_bus_odd_refused: assert property (
    internal_peripheral_bus_req_i.req && internal_peripheral_bus_req_i.addr[0]
    |=> internal_peripheral_bus_rsp_o.err)
    else $error("odd byte address accepted");

  a_expansion_peripheral_bus_bitop_refused: assert property (
    expansion_peripheral_bus_req_i.req && expansion_peripheral_bus_req_i.bitop
    |=> expansion_peripheral_bus_rsp_o.err && $stable(flash_unprot_o))
    else $error("bit access to unprotect register not refused");

  a_expansion_peripheral_bus_part_refused: assert property (
    expansion_peripheral_bus_req_i.req && !expansion_peripheral_bus_req_i.word
    |=> expansion_peripheral_bus_rsp_o.err && $stable(flash_unprot_o))
    else $error("partial access to unprotect register accepted");

  a_expansion_peripheral_bus_wrong_addr: assert property (
    expansion_peripheral_bus_req_i.req && expansion_peripheral_bus_req_i.addr != ADDR_UNPROT
    |=> expansion_peripheral_bus_rsp_o.err && $stable(flash_unprot_o))
    else $error("expansion bus answered a foreign address");

  a_expansion_peripheral_bus_read_data: assert property (
    expansion_peripheral_bus_req_i.req && !expansion_peripheral_bus_req_i.we && whole_word(expansion_peripheral_bus_req_i) &&
    expansion_peripheral_bus_req_i.addr == ADDR_UNPROT |=> expansion_peripheral_bus_rsp_o.rdata == $past(flash_unprot_o))
    else $error("unprotect register read data wrong");

  // the two buses own disjoint storage, so one never disturbs the other
  a_internal_peripheral_bus_leaves_unprot: assert property (
    internal_peripheral_bus_req_i.req && !expansion_peripheral_bus_req_i.req
    |=> $stable(flash_unprot_o))
    else $error("peripheral bus touched unprotect register");

  a_expansion_peripheral_bus_leaves_regs: assert property (
    expansion_peripheral_bus_req_i.req && !internal_peripheral_bus_req_i.req
    |=> $stable(q.regs))
    else $error("expansion bus touched flash registers");

  a_extended_sfr_space_unmapped: assert property (
    extended_sfr_space_req_i.req && !id_hit
    |=> extended_sfr_space_rsp_o.err && extended_sfr_space_rsp_o.rdata == '0)
    else $error("unmapped identification address accepted");

  a_extended_sfr_space_leaves_state: assert property (
    extended_sfr_space_req_i.req && !internal_peripheral_bus_req_i.req && !expansion_peripheral_bus_req_i.req
    |=> $stable(q.regs) && $stable(flash_unprot_o))
    else $error("identification access changed a register");

  a_maker_word: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_MAKER_ID
    |=> extended_sfr_space_rsp_o.rdata == {MAKER_CODE, MAKER_TAIL})
    else $error("maker word wrong");

  a_mem_capacity_field: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_MEM_ID
    |=> extended_sfr_space_rsp_o.rdata[11:0] == MEM_CAPACITY)
    else $error("memory capacity field wrong");

  a_mem_kind_field: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_MEM_ID && id_valid_o
    |=> extended_sfr_space_rsp_o.rdata[15:12] == FIR_KIND_FAST)
    else $error("memory kind field wrong");

  a_prog_supply_field: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_PROG_ID
    |=> extended_sfr_space_rsp_o.rdata[7:0] == PROG_SUPPLY)
    else $error("program supply field wrong");

  a_prog_high_field: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_PROG_ID
    |=> extended_sfr_space_rsp_o.rdata[15:8] == PROG_HIGH_V)
    else $error("program high-voltage field wrong");

  a_valid_sticks: assert property (
    id_valid_o
    |=> id_valid_o)
    else $error("identification valid dropped before reset");

  a_init_done_taken: assert property (
    q.phase == FIR_PH_INIT && flash_init_done_i
    |=> id_valid_o)
    else $error("flash init done not taken");

  a_external_boot_waits: assert property (
    $rose(nrst_i) ##0 (!external_boot_select_n_i [*3])
    |=> !id_valid_o)
    else $error("external boot valid before flash init");

  a_early_top_bits: assert property (
    extended_sfr_space_req_i.req && !extended_sfr_space_req_i.we && extended_sfr_space_req_i.addr == ADDR_MEM_ID && !id_valid_o
    |=> extended_sfr_space_rsp_o.rdata[15:14] == 2'h3)
    else $error("memory word top bits low before init");

  a_reset_outputs: assert property (
    $rose(nrst_i)
    |-> internal_peripheral_bus_rsp_o == '0 && expansion_peripheral_bus_rsp_o == '0 && extended_sfr_space_rsp_o == '0 && !id_valid_o)
    else $error("outputs not quiet after reset");

  c_internal_boot: cover property (q.phase == FIR_PH_SYNC ##1 q.phase == FIR_PH_READY);
  c_external_wait: cover property (q.phase == FIR_PH_INIT ##1 q.phase == FIR_PH_READY);
  c_internal_peripheral_bus_write: cover property (internal_peripheral_bus_req_i.req && internal_peripheral_bus_req_i.we && ib_ok);
  c_id_poll_early: cover property (extended_sfr_space_req_i.req && extended_sfr_space_req_i.addr == ADDR_MEM_ID
    && !id_valid_o);
  c_expansion_peripheral_bus_write: cover property (expansion_peripheral_bus_req_i.req && expansion_peripheral_bus_req_i.we
    && expansion_peripheral_bus_req_i.addr == ADDR_UNPROT);

endmodule // fir_bank

/* File: hw/fir_pkg.sv */
// constants and types for the flash register bank and identification words
package fir_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  localparam int NREG = 15;
  localparam int IW = 5;
  localparam logic [IW-1:0] IDX_NONE = 5'h0F;
  localparam logic [1:0] SYNC_FILL = 2'h2;

  // peripheral-bus map, index order is the storage order
  localparam logic [NREG-1:0][AW-1:0] REG_ADDR = '{
    24'h08DFBE, 24'h08DFBC, 24'h08DFB8, 24'h08DFB0, 24'h080014,
    24'h080012, 24'h080010, 24'h08000E, 24'h08000C, 24'h08000A,
    24'h080008, 24'h080006, 24'h080004, 24'h080002, 24'h080000};
  localparam logic [NREG-1:0][DW-1:0] REG_RST = '{
    16'hFFFF, 16'hFFFF, 16'hACFF, 16'hFFFF, 16'h0000,
    16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam int NCTRL = 4;

  localparam logic [AW-1:0] ADDR_UNPROT = 24'h00EB50;
  localparam logic [DW-1:0] UNPROT_RST = 16'h0000;
  localparam logic [AW-1:0] ADDR_PROG_ID = 24'h00F078;
  localparam logic [AW-1:0] ADDR_MEM_ID = 24'h00F07A;
  localparam logic [AW-1:0] ADDR_CHIP_ID = 24'h00F07C;
  localparam logic [AW-1:0] ADDR_MAKER_ID = 24'h00F07E;

  typedef enum logic [3:0] {
    FIR_KIND_NONE = 4'h0,
    FIR_KIND_ROM = 4'h1,
    FIR_KIND_FLASH = 4'h2,
    FIR_KIND_FAST = 4'h3,
    FIR_KIND_UNSET = 4'hF
  } fir_kind_e;
  localparam logic [11:0] MEM_CAPACITY = 12'h040;
  localparam logic [7:0] PROG_SUPPLY = 8'h40;
  localparam logic [7:0] PROG_HIGH_V = 8'h00;
  localparam logic [4:0] MAKER_TAIL = 5'h03;

  typedef enum logic [2:0] {
    FIR_PH_SYNC = 3'b001,
    FIR_PH_INIT = 3'b010,
    FIR_PH_READY = 3'b100
  } fir_phase_e;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic bitop;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } fir_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [DW-1:0] rdata;
  } fir_rsp_s;

  typedef struct packed {
    logic [NREG-1:0][DW-1:0] regs;
    logic [DW-1:0] unprot;
    logic [1:0] boot_sync;
    fir_phase_e phase;
    logic [1:0] fill;
    fir_rsp_s ib;
    fir_rsp_s xb;
    fir_rsp_s es;
  } fir_state_s;

  localparam fir_state_s STATE_RST = '{
    regs: REG_RST, unprot: UNPROT_RST, boot_sync: 2'h0,
    phase: FIR_PH_SYNC, fill: 2'h0,
    ib: '0, xb: '0, es: '0};
endpackage

/* File: tb/fir_cpu.sv */
// cpu-side bus master model for the flash register bank
`timescale 1ns/1ps
module fir_cpu
  import fir_pkg::*;
(
  // clock
  input wire logic clk_i,
  // requests towards the bank
  output fir_pkg::fir_req_s internal_peripheral_bus_req_o,
  output fir_pkg::fir_req_s expansion_peripheral_bus_req_o,
  output fir_pkg::fir_req_s extended_sfr_space_req_o,
  // answers from the bank
  input wire fir_pkg::fir_rsp_s internal_peripheral_bus_rsp_i,
  input wire fir_pkg::fir_rsp_s expansion_peripheral_bus_rsp_i,
  input wire fir_pkg::fir_rsp_s extended_sfr_space_rsp_i
);
  initial begin
    internal_peripheral_bus_req_o = '0;
    expansion_peripheral_bus_req_o = '0;
    extended_sfr_space_req_o = '0;
  end

  // one access; idle bus shows inverted lines so stale values never look valid
  task automatic acc(input int p, input logic [2:0] c, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, output fir_rsp_s r);
    fir_req_s q;
    fir_req_s idle;
    q = '{req: 1'h1, we: c[2], word: c[1], bitop: c[0], addr: a, wdata: d};
    idle = ~q;
    idle.req = 1'h0;
    @(posedge clk_i);
    #1;
    if (p == 0) internal_peripheral_bus_req_o = q;
    else if (p == 1) expansion_peripheral_bus_req_o = q;
    else extended_sfr_space_req_o = q;
    @(posedge clk_i);
    #1;
    r = (p == 0) ? internal_peripheral_bus_rsp_i : (p == 1) ? expansion_peripheral_bus_rsp_i : extended_sfr_space_rsp_i;
    if (p == 0) internal_peripheral_bus_req_o = idle;
    else if (p == 1) expansion_peripheral_bus_req_o = idle;
    else extended_sfr_space_req_o = idle;
  endtask

  // external boot: trust the words only once both top bits read low
  task automatic poll(output logic ok);
    fir_rsp_s r;
    ok = 1'h0;
    for (int i = 0; i < 64 && ok !== 1'h1; i++) begin
      acc(2, 3'h2, ADDR_MEM_ID, 16'h0000, r);
      ok = (r.rdata[15:14] === 2'h0) && (r.ack === 1'h1);
    end
  endtask
endmodule // fir_cpu

/* File: tb/tb.sv */
// self-checking bench for the flash register bank
`timescale 1ns/1ps
module tb;
  import fir_pkg::*;
  typedef struct packed {
    logic [1:0] p;
    logic [2:0] c;
    logic [23:0] a;
    logic [15:0] d;
    logic e;
    logic [15:0] r;
  } fir_row_s;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic boot_n = 1'h1;
  logic init_done = 1'h0;
  logic ok;
  fir_req_s ibq, xbq, esq;
  fir_rsp_s ibr, xbr, esr, r;
  logic [NCTRL-1:0][DW-1:0] fctl;
  logic [DW-1:0] funp;
  logic idv;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [23:0] ra [15];
  logic [15:0] rv [15];
  fir_row_s rows [19];

  always begin
    #12.5;
    clk_i = ~clk_i;
  end

  fir_bank #(.MAKER_CODE(11'h2AB), .CHIP_CODE(12'h3C7), .REVISION(4'h9)) i_fir_bank (
    .clk_i(clk_i), .nrst_i(nrst_i), .external_boot_select_n_i(boot_n),
    .flash_init_done_i(init_done), .internal_peripheral_bus_req_i(ibq), .internal_peripheral_bus_rsp_o(ibr),
    .expansion_peripheral_bus_req_i(xbq), .expansion_peripheral_bus_rsp_o(xbr), .extended_sfr_space_req_i(esq), .extended_sfr_space_rsp_o(esr),
    .flash_ctrl_o(fctl), .flash_unprot_o(funp), .id_valid_o(idv));
  fir_cpu i_fir_cpu (
    .clk_i(clk_i), .internal_peripheral_bus_req_o(ibq), .expansion_peripheral_bus_req_o(xbq), .extended_sfr_space_req_o(esq),
    .internal_peripheral_bus_rsp_i(ibr), .expansion_peripheral_bus_rsp_i(xbr), .extended_sfr_space_rsp_i(esr));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic rd(input int p, input logic [23:0] a, input logic [15:0] ex);
    i_fir_cpu.acc(p, 3'h2, a, 16'h0000, r);
    chk("read ack", 16'h0002, {14'h0, r.ack, r.err});
    chk("read data", ex, r.rdata);
  endtask

  task automatic reset_dut(input logic bn);
    @(posedge clk_i);
    #1;
    nrst_i = 1'h0;
    boot_n = bn;
    init_done = 1'h0;
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'h1;
  endtask

  // a hang costs one mismatch and ends the run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      $display("BAD timeout expected done seen hang");
      close_out;
    end
  end

  initial begin
    for (int i = 0; i < 11; i++) begin
      ra[i] = 24'h080000 + 24'(2 * i);
      rv[i] = (i >= 4 && i <= 7) ? 16'hFFFF : 16'h0000;
    end
    ra[11:14] = '{24'h08DFB0, 24'h08DFB8, 24'h08DFBC, 24'h08DFBE};
    rv[11:14] = '{16'hFFFF, 16'hACFF, 16'hFFFF, 16'hFFFF};
    rows = '{
      '{2, 3'h2, 24'h00F078, 16'h0000, 0, 16'h0040},
      '{2, 3'h2, 24'h00F07A, 16'h0000, 0, 16'h3040},
      '{2, 3'h6, 24'h00F07A, 16'h1234, 0, 16'h0000},
      '{2, 3'h2, 24'h00F07A, 16'h0000, 0, 16'h3040},
      '{2, 3'h2, 24'h00F07C, 16'h0000, 0, 16'h3C79},
      '{2, 3'h2, 24'h00F07E, 16'h0000, 0, 16'h5563},
      '{2, 3'h2, 24'h00F070, 16'h0000, 1, 16'h0000},
      '{0, 3'h0, 24'h080000, 16'h0000, 1, 16'h0000},
      '{0, 3'h7, 24'h080000, 16'hBEEF, 1, 16'h0000},
      '{0, 3'h2, 24'h080000, 16'h0000, 0, 16'h0000},
      '{0, 3'h2, 24'h080001, 16'h0000, 1, 16'h0000},
      '{0, 3'h2, 24'h00EB50, 16'h0000, 1, 16'h0000},
      '{1, 3'h2, 24'h00EB50, 16'h0000, 0, 16'h0000},
      '{1, 3'h6, 24'h00EB50, 16'h5A5A, 0, 16'h0000},
      '{1, 3'h4, 24'h00EB50, 16'h1111, 1, 16'h0000},
      '{1, 3'h7, 24'h00EB50, 16'h2222, 1, 16'h0000},
      '{1, 3'h2, 24'h00EB50, 16'h0000, 0, 16'h5A5A},
      '{1, 3'h2, 24'h080000, 16'h0000, 1, 16'h0000},
      '{0, 3'h2, 24'h080016, 16'h0000, 1, 16'h0000}};
    reset_dut(1'h1);
    repeat (2) @(posedge clk_i);
    #1;
    chk("id valid early", 16'h0000, {15'h0, idv});
    @(posedge clk_i);
    #1;
    chk("id valid", 16'h0001, {15'h0, idv});
    for (int i = 0; i < 15; i++) rd(0, ra[i], rv[i]);
    $display("test reset values done");
    foreach (rows[i]) begin
      i_fir_cpu.acc(rows[i].p, rows[i].c, rows[i].a, rows[i].d, r);
      chk("ack err", {14'h0, 1'h1, rows[i].e}, {14'h0, r.ack, r.err});
      chk("rdata", rows[i].r, r.rdata);
    end
    chk("unprotect out", 16'h5A5A, funp);
    $display("test table done");
    for (int i = 0; i < 15; i++) begin
      i_fir_cpu.acc(0, 3'h6, ra[i], 16'hA500 + 16'(i), r);
      rd(0, ra[i], 16'hA500 + 16'(i));
    end
    for (int j = 0; j < 4; j++) chk("control out", 16'hA500 + 16'(j), fctl[j]);
    $display("test write back done");
    // second reset mid-run, now booting from external memory
    reset_dut(1'h0);
    repeat (8) @(posedge clk_i);
    #1;
    chk("id valid wait", 16'h0000, {15'h0, idv});
    rd(2, ADDR_MEM_ID, 16'hF040);
    rd(2, ADDR_PROG_ID, 16'h0040);
    rd(1, ADDR_UNPROT, 16'h0000);
    init_done = 1'h1;
    i_fir_cpu.poll(ok);
    chk("poll done", 16'h0001, {15'h0, ok});
    rd(2, ADDR_MEM_ID, 16'h3040);
    chk("id valid late", 16'h0001, {15'h0, idv});
    $display("test external boot done");
    close_out;
  end
endmodule // tb
